// ---- hw/light_sensor_readout_regs.sv ----
`default_nettype none
//
// Contract
// - gain level bit scales 1x/8x by 0.16
// - wait long multiplies wait by 12
// - gain select picks 1x/8x/16x/120x
// - read-only part id at 0x12
// - status read-only, reserved bits zero
// - status bit 4 mirrors interrupt
// - status bit 0 set after integration
// - 16-bit counts, low byte even address
// - low-byte read latches high shadow
// - shadow holds despite new results
// - interrupt and bus lines open-drain; here only the interrupt is, o_rdata is driven both ways
// - interrupt on ch0 outside thresholds
// - wait field two's complement steps
// - measure enable starts converter
module light_sensor_readout_regs #(
  parameter logic [7:0] PART_ID = 8'h5a  // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire light_sensor_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  input wire light_sensor_pkg::result_t i_result,
  input wire logic i_measure_enable,
  input wire logic i_light_irq_mask,
  input wire logic [15:0] i_low_threshold,
  input wire logic [15:0] i_high_threshold,
  input wire logic [7:0] i_wait_time_field,
  input wire logic i_irq_pin,
  output logic o_irq_out,
  output logic o_irq_oe_n,
  output logic [6:0] o_gain_value,
  output logic [6:0] o_gain_scale,
  output logic [12:0] o_wait_steps
);
  logic [7:0] config_reg;
  logic [7:0] gain_reg;
  logic [15:0] ch0_reg;
  logic [15:0] ch1_reg;
  logic [7:0] shadow0_reg;
  logic [7:0] shadow1_reg;
  logic valid_reg;
  logic irq_reg;
  logic irq_level;
  logic [7:0] status_value;
  logic [8:0] wait_base;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // read back of the shared line, so status shows what the pin carries
  open_drain_sync u_irq_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin(i_irq_pin),
    .o_level(irq_level)
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      config_reg <= light_sensor_pkg::CONFIG_RESET;
    else if (i_req.wr && hit(i_req.addr, light_sensor_pkg::CONFIG_ADDR))
      config_reg <= i_req.wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      gain_reg <= light_sensor_pkg::GAIN_RESET;
    else if (i_req.wr && hit(i_req.addr, light_sensor_pkg::GAIN_ADDR))
      gain_reg <= i_req.wdata;
  end

  // results land only from the converter; bus writes never reach them
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ch0_reg <= 16'h0000;
      ch1_reg <= 16'h0000;
    end
    else if (i_result.done && i_measure_enable)
    begin
      ch0_reg <= i_result.ch0;
      ch1_reg <= i_result.ch1;
    end
  end

  // valid clears when measuring stops
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      valid_reg <= 1'b0;
    else if (!i_measure_enable)
      valid_reg <= 1'b0;
    else if (i_result.done)
      valid_reg <= 1'b1;
  end

  // threshold compare on each fresh ch0 result, gated by the mask
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      irq_reg <= 1'b0;
    else if (!i_light_irq_mask || !i_measure_enable)
      irq_reg <= 1'b0;
    else if (i_result.done)
      irq_reg <= (i_result.ch0 < i_low_threshold) ||
                 (i_result.ch0 > i_high_threshold);
  end

  // shadows are loaded only on their own low read, so pairs stay whole
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      shadow0_reg <= 8'h00;
    else if (i_req.rd && hit(i_req.addr, light_sensor_pkg::CH0_LOW_ADDR))
      shadow0_reg <= ch0_reg[15:8];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      shadow1_reg <= 8'h00;
    else if (i_req.rd && hit(i_req.addr, light_sensor_pkg::CH1_LOW_ADDR))
      shadow1_reg <= ch1_reg[15:8];
  end

  always_comb
  begin
    status_value = 8'h00;
    status_value[light_sensor_pkg::IRQ_FLAG_BIT] = !irq_level;
    status_value[light_sensor_pkg::VALID_BIT] = valid_reg;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_req.rd)
    begin
      case (i_req.addr)
        light_sensor_pkg::CONFIG_ADDR: o_rdata <= config_reg;
        light_sensor_pkg::GAIN_ADDR: o_rdata <= gain_reg;
        light_sensor_pkg::ID_ADDR: o_rdata <= PART_ID;
        light_sensor_pkg::STATUS_ADDR: o_rdata <= status_value;
        light_sensor_pkg::CH0_LOW_ADDR: o_rdata <= ch0_reg[7:0];
        light_sensor_pkg::CH0_HIGH_ADDR: o_rdata <= shadow0_reg;
        light_sensor_pkg::CH1_LOW_ADDR: o_rdata <= ch1_reg[7:0];
        light_sensor_pkg::CH1_HIGH_ADDR: o_rdata <= shadow1_reg;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // open drain: only ever pull low, enable low while pulling
  assign o_irq_out = 1'b0;
  assign o_irq_oe_n = !irq_reg;

  always_comb
  begin
    case (light_sensor_pkg::gain_sel_t'(gain_reg[1:0]))
      light_sensor_pkg::GAIN_SEL_1X: o_gain_value = light_sensor_pkg::GAIN_1X;
      light_sensor_pkg::GAIN_SEL_8X: o_gain_value = light_sensor_pkg::GAIN_8X;
      light_sensor_pkg::GAIN_SEL_16X:
        o_gain_value = light_sensor_pkg::GAIN_16X;
      light_sensor_pkg::GAIN_SEL_120X:
        o_gain_value = light_sensor_pkg::GAIN_120X;
      default: o_gain_value = light_sensor_pkg::GAIN_1X;
    endcase
  end

  // scaling above 8x is left unsupported, so no guard is spent on it
  assign o_gain_scale = config_reg[light_sensor_pkg::GAIN_LEVEL_BIT] ?
    light_sensor_pkg::SCALE_LOW : light_sensor_pkg::SCALE_UNITY;

  // 0xff gives one step, 0x00 gives 256
  assign wait_base = 9'h100 - {1'b0, i_wait_time_field};
  // widen before the product, a 9-bit product would wrap above 511
  assign o_wait_steps = config_reg[light_sensor_pkg::WAIT_LONG_BIT] ?
    13'(wait_base) * 13'(light_sensor_pkg::WAIT_LONG_FACTOR) :
    13'(wait_base);

  chk_gain_scale_low: assert property (
    @(posedge i_clk) disable iff (i_rst)
    config_reg[light_sensor_pkg::GAIN_LEVEL_BIT] |->
    o_gain_scale == light_sensor_pkg::SCALE_LOW)
    else $error("gain scale wrong");
  chk_wait_long_mul: assert property (
    @(posedge i_clk) disable iff (i_rst)
    config_reg[light_sensor_pkg::WAIT_LONG_BIT] |->
    o_wait_steps == 13'(wait_base * light_sensor_pkg::WAIT_LONG_FACTOR))
    else $error("wait long factor wrong");
  chk_gain_sel_120: assert property (
    @(posedge i_clk) disable iff (i_rst)
    gain_reg[1:0] == light_sensor_pkg::GAIN_SEL_120X |->
    o_gain_value == light_sensor_pkg::GAIN_120X)
    else $error("gain select wrong");
  chk_id_read_back: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.addr == light_sensor_pkg::ID_ADDR |=>
    o_rdata == PART_ID)
    else $error("id read wrong");
  chk_status_reserved: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.addr == light_sensor_pkg::STATUS_ADDR |=>
    o_rdata[7:5] == 3'h0 && o_rdata[3:1] == 3'h0)
    else $error("status reserved bits set");
  chk_valid_after_done: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_result.done && i_measure_enable |=> valid_reg)
    else $error("valid not set");
  chk_shadow_holds: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !(i_req.rd && i_req.addr == light_sensor_pkg::CH0_LOW_ADDR) |=>
    $stable(shadow0_reg))
    else $error("shadow changed");
  chk_shadow_loads: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_req.rd && i_req.addr == light_sensor_pkg::CH1_LOW_ADDR |=>
    shadow1_reg == $past(ch1_reg[15:8]))
    else $error("shadow not loaded");
  chk_ro_no_write: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_req.wr && !i_result.done |=> $stable(ch0_reg))
    else $error("result changed by write");
  chk_irq_release: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_light_irq_mask || !i_measure_enable |=>
    o_irq_oe_n && o_irq_out == 1'b0)
    else $error("interrupt not released");
endmodule
`default_nettype wire

// ---- hw/light_sensor_pkg.sv ----
`default_nettype none
package light_sensor_pkg;
  localparam logic [7:0] CONFIG_ADDR = 8'h0d;
  localparam logic [7:0] GAIN_ADDR = 8'h0f;
  localparam logic [7:0] ID_ADDR = 8'h12;
  localparam logic [7:0] STATUS_ADDR = 8'h13;
  localparam logic [7:0] CH0_LOW_ADDR = 8'h14;
  localparam logic [7:0] CH0_HIGH_ADDR = 8'h15;
  localparam logic [7:0] CH1_LOW_ADDR = 8'h16;
  localparam logic [7:0] CH1_HIGH_ADDR = 8'h17;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam int GAIN_LEVEL_BIT = 2;
  localparam int WAIT_LONG_BIT = 1;
  localparam int IRQ_FLAG_BIT = 4;
  localparam int VALID_BIT = 0;
  localparam int WAIT_LONG_FACTOR = 12;
  // gain scale in hundredths: 0.16 or 1
  localparam logic [6:0] SCALE_LOW = 7'h10;
  localparam logic [6:0] SCALE_UNITY = 7'h64;
  localparam logic [6:0] GAIN_1X = 7'h01;
  localparam logic [6:0] GAIN_8X = 7'h08;
  localparam logic [6:0] GAIN_16X = 7'h10;
  localparam logic [6:0] GAIN_120X = 7'h78;
  // one wait step 2.73 ms, in microseconds
  localparam int WAIT_STEP_US = 2730;
  localparam int CLK_MHZ = 50;
  localparam int WAIT_STEP_CYCLES = WAIT_STEP_US * CLK_MHZ;
  typedef enum logic [1:0] {
    GAIN_SEL_1X = 2'b00,
    GAIN_SEL_8X = 2'b01,
    GAIN_SEL_16X = 2'b10,
    GAIN_SEL_120X = 2'b11
  } gain_sel_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic done;
  } result_t;
endpackage
`default_nettype wire

// ---- hw/open_drain_sync.sv ----
`default_nettype none
// three-stage sampler; level changes when stages two and three agree
module open_drain_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_level
);
  logic [2:0] stage_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      stage_reg <= 3'h7;
    else
      stage_reg <= {stage_reg[1:0], i_pin};
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_level <= 1'b1;
    else if (stage_reg[1] == stage_reg[2])
      o_level <= stage_reg[2];
  end
endmodule
`default_nettype wire

// ---- verification/irq_line_model.sv ----
`default_nettype none
// host side of the interrupt wire: a pull-up, so a released line reads high
module irq_line_model (
  input wire logic i_oe_n,
  input wire logic i_data,
  output logic o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_level = i_oe_n ? 1'b1 : i_data;
endmodule
`default_nettype wire

// ---- verification/light_sensor_readout_regs_test.sv ----
`default_nettype none
module light_sensor_readout_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ID_VAL = 8'h5a; // arbitrary value
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  light_sensor_pkg::reg_req_t req = '0;
  light_sensor_pkg::result_t res = '0;
  logic en = 1'b0;
  logic mask = 1'b0;
  logic [15:0] lo_th = 16'h0100;
  logic [15:0] hi_th = 16'h0200;
  logic [7:0] wt = 8'h00;
  logic [7:0] rdata;
  logic irq_out, irq_oe_n, irq_wire;
  logic [6:0] gval, gscale;
  logic [12:0] wsteps;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [6:0] gains [4] = '{7'h01, 7'h08, 7'h10, 7'h78};
  logic [15:0] c0, c1;
  int failures = 0;
  int check_count = 0;
  integer seed = 33;

  always #10 i_clk = ~i_clk;

  light_sensor_readout_regs #(.PART_ID(ID_VAL)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
    .i_result(res), .i_measure_enable(en), .i_light_irq_mask(mask),
    .i_low_threshold(lo_th), .i_high_threshold(hi_th),
    .i_wait_time_field(wt), .i_irq_pin(irq_wire), .o_irq_out(irq_out),
    .o_irq_oe_n(irq_oe_n), .o_gain_value(gval), .o_gain_scale(gscale),
    .o_wait_steps(wsteps)
  );

  irq_line_model u_irq (
    .i_oe_n(irq_oe_n), .i_data(irq_out), .o_level(irq_wire)
  );

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic access(logic [7:0] a, logic w, logic [7:0] d);
    @(negedge i_clk);
    req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge i_clk);
    req = '0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    access(a, 1'b0, 8'h00);
  endtask

  task automatic result(logic [15:0] a, logic [15:0] b);
    @(negedge i_clk);
    res = '{ch0: a, ch1: b, done: 1'b1};
    @(negedge i_clk);
    res.done = 1'b0;
  endtask

  task automatic end_of_test();
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // read data lands on the edge after the request, so look at the negedge
  always @(posedge i_clk) rd_seen <= req.rd;
  always @(negedge i_clk)
    if (rd_seen)
      check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});

  initial
  begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    rd(8'h0d, 8'h00);
    rd(8'h0f, 8'h00);
    rd(8'h12, ID_VAL);
    rd(8'h13, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h20, 8'h00);
    access(8'h12, 1'b1, 8'ha5);
    access(8'h13, 1'b1, 8'hff);
    access(8'h14, 1'b1, 8'h3c);
    rd(8'h12, ID_VAL);
    rd(8'h13, 8'h00);
    rd(8'h14, 8'h00);
    // gain level only with the two low gains, never above 8x
    for (int g = 0; g < 4; g++)
    begin
      wt = 8'($random(seed));
      access(8'h0f, 1'b1, 8'(g));
      access(8'h0d, 1'b1, {5'h00, (g < 2), g[0], 1'b0});
      rd(8'h0f, 8'(g));
      check("gain", {9'h000, gains[g]}, {9'h000, gval});
      check("scale", (g < 2) ? 16'h0010 : 16'h0064,
        {9'h000, gscale});
      check("wait", (16'h0100 - {8'h00, wt}) *
        (g[0] ? 16'h000c : 16'h0001), {3'h0, wsteps});
    end
    en = 1'b1;
    c0 = 16'($random(seed));
    c1 = 16'($random(seed));
    result(c0, c1);
    rd(8'h13, 8'h01);
    rd(8'h14, c0[7:0]);
    result(~c0, ~c1);
    rd(8'h15, c0[15:8]);
    // low then high byte straight after, as a two-byte read does
    rd(8'h16, ~c1[7:0]);
    rd(8'h17, ~c1[15:8]);
    mask = 1'b1;
    result(16'h0050, c1);
    check("irq_oe_n", 16'h0000, {15'h0000, irq_oe_n});
    check("irq_out", 16'h0000, {15'h0000, irq_out});
    repeat (6) @(negedge i_clk);
    rd(8'h13, 8'h11);
    result(16'h0150, c1);
    check("irq_oe_n", 16'h0001, {15'h0000, irq_oe_n});
    repeat (6) @(negedge i_clk);
    rd(8'h13, 8'h01);
    result(16'h0250, c1);
    check("irq_oe_n", 16'h0000, {15'h0000, irq_oe_n});
    mask = 1'b0;
    @(negedge i_clk);
    @(negedge i_clk);
    check("irq_oe_n", 16'h0001, {15'h0000, irq_oe_n});
    // stopping the converter drops the valid flag
    en = 1'b0;
    repeat (4) @(negedge i_clk);
    rd(8'h13, 8'h00);
    // a second reset in mid-run brings back the config, ch0 low, ch0 shadow and gain scale reset values
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    rd(8'h0d, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h14, 8'h00);
    check("scale", 16'h0064, {9'h000, gscale});
    repeat (2) @(negedge i_clk);
    end_of_test();
  end

  // the whole sequence is about a hundred cycles; this is far beyond it
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
